// >>> logic/fps_seq.sv
`timescale 1ns/100ps
module fps_seq
  import fps_pkg::*;
#(
  parameter int ADDR_W       = 16,
  parameter int ERASE_CYC    = ERASE_CYCLES,
  parameter int PROG_CYC     = PROG_CYCLES
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic [3:0]        i_reg_addr,
  input  wire logic [15:0]       i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic      [15:0]       o_reg_rdata,
  input  wire logic              i_tbl_wr_low,
  input  wire logic [15:0]       i_tbl_offset,
  output logic                   o_cpu_stall,
  output logic                   o_flash_erase,
  output logic                   o_flash_program,
  output logic      [ADDR_W-1:0] o_flash_addr
);
  localparam int PG_SHIFT = $clog2(PAGE_WORDS * 2);

  typedef struct packed {
    fps_state_t        st;
    fps_key_t          key;
    logic [15:0]       ctrl;
    logic [7:0]        page_ptr;
    logic [ADDR_W-1:0] erase_page;
    logic [ADDR_W-1:0] row_addr;
    logic [31:0]       cnt;
    logic              done;
    logic              refused;
    logic [15:0]       rdata;
  } fps_regs_t;

  fps_regs_t s_r;
  fps_regs_t s_nxt;

  // Page base from pointer and in-page offset, rounded to page
  function automatic logic [ADDR_W-1:0] page_base(input logic [7:0] ptr,
                                                  input logic [15:0] off);
    logic [39:0] full;
    full = {16'h0000, ptr, off} >> PG_SHIFT;
    page_base = ADDR_W'(full << PG_SHIFT);
  endfunction

  always_comb begin
    logic go_req;
    s_nxt  = s_r;
    go_req = i_reg_wr && (i_reg_addr == ADDR_CONTROL) && i_reg_wdata[BIT_GO];
    // Read data valid the cycle after the read strobe
    s_nxt.rdata = 16'h0000;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_CONTROL:  s_nxt.rdata = s_r.ctrl;
        ADDR_PAGE_PTR: s_nxt.rdata = {8'h00, s_r.page_ptr};
        ADDR_ERASE_PG: s_nxt.rdata = 16'(s_r.erase_page);
        ADDR_STATUS:   s_nxt.rdata = {13'h0000, s_r.refused, s_r.done,
                                      s_r.st != FPS_IDLE};
        default:       s_nxt.rdata = 16'h0000;
      endcase
    end
    if (i_tbl_wr_low && s_r.st == FPS_IDLE) begin
      s_nxt.erase_page = page_base(s_r.page_ptr, i_tbl_offset);
      s_nxt.row_addr   = page_base(s_r.page_ptr, i_tbl_offset);
    end
    unique case (s_r.st)
      FPS_IDLE: begin
        if (i_reg_wr) begin
          // Any write other than the next key step drops the partial key
          s_nxt.key = KEY_NONE;
          if (i_reg_addr == ADDR_KEY) begin
            if (i_reg_wdata[7:0] == KEY_FIRST) begin
              s_nxt.key = KEY_GOT55;
            end else if (i_reg_wdata[7:0] == KEY_SECOND && s_r.key == KEY_GOT55) begin
              s_nxt.key = KEY_OPEN;
            end
          end else if (i_reg_addr == ADDR_PAGE_PTR) begin
            s_nxt.page_ptr = i_reg_wdata[7:0];
          end else if (i_reg_addr == ADDR_STATUS) begin
            s_nxt.done    = s_r.done & ~i_reg_wdata[1];
            s_nxt.refused = s_r.refused & ~i_reg_wdata[2];
          end else if (i_reg_addr == ADDR_CONTROL) begin
            s_nxt.ctrl = (i_reg_wdata & CONTROL_WMASK) | (s_r.ctrl & ~CONTROL_WMASK);
          end
        end
        if (go_req) begin
          s_nxt.cnt = 32'h0000_0000;
          if (s_r.key != KEY_OPEN || !i_reg_wdata[BIT_WPERMIT]) begin
            s_nxt.refused = 1'b1;
          end else if (i_reg_wdata[3:0] == OP_PAGE_ERASE && i_reg_wdata[BIT_ERASE]) begin
            s_nxt.st = FPS_ERASE;
            s_nxt.ctrl[BIT_GO] = 1'b1;
          end else if (i_reg_wdata[3:0] == OP_ROW_PROGRAM && !i_reg_wdata[BIT_ERASE]) begin
            s_nxt.st = FPS_PROG;
            s_nxt.ctrl[BIT_GO] = 1'b1;
          end else begin
            s_nxt.refused = 1'b1;
          end
        end
      end
      FPS_ERASE: begin
        s_nxt.key = KEY_NONE;
        s_nxt.cnt = s_r.cnt + 32'h0000_0001;
        if (s_r.cnt == 32'(ERASE_CYC - 1)) begin
          s_nxt.st = FPS_IDLE;
          s_nxt.ctrl[BIT_GO] = 1'b0;
          s_nxt.done = 1'b1;
        end
      end
      FPS_PROG: begin
        s_nxt.key = KEY_NONE;
        s_nxt.cnt = s_r.cnt + 32'h0000_0001;
        if (s_r.cnt == 32'(PROG_CYC - 1)) begin
          s_nxt.st = FPS_IDLE;
          s_nxt.ctrl[BIT_GO] = 1'b0;
          s_nxt.done = 1'b1;
          // Advance to next row; the next low table write in idle reloads the page base
          s_nxt.row_addr = s_r.row_addr + ADDR_W'(ROW_WORDS * 2);
        end
      end
      // Unused state code falls back to idle rather than locking the core
      default: begin
        s_nxt.st  = FPS_IDLE;
        s_nxt.key = KEY_NONE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '{st: FPS_IDLE, key: KEY_NONE, ctrl: CONTROL_RESET, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_reg_rdata     = s_r.rdata;
  assign o_cpu_stall     = s_r.st != FPS_IDLE;
  assign o_flash_erase   = s_r.st == FPS_ERASE;
  assign o_flash_program = s_r.st == FPS_PROG;
  assign o_flash_addr    = (s_r.st == FPS_ERASE) ? s_r.erase_page : s_r.row_addr;
endmodule

// >>> include/fps_pkg.sv
// How it works
// - Program flash one row at a time, 64 instructions from latch buffers.
// - Erase unit is an eight-row page of 512 instructions.
// - Operation code in control bits 3..0; 0010 selects page erase.
// - Erase flag bit 6 and write-permit bit 14 both set for erase.
// - Dummy low-word table write picks the page from page pointer and offset.
// - No erase or program starts without the unlock key sequence.
// - Go bit 15 starts the operation; processor stalls throughout.
// - Go bit clears by hardware when the operation finishes.
// - Code 0001 selects row program; erase flag clear, write permit set.
// - Processor stalls during row programming until the write completes.
package fps_pkg;
  localparam logic [3:0]  ADDR_CONTROL   = 4'h0;
  localparam logic [3:0]  ADDR_KEY       = 4'h1;
  localparam logic [3:0]  ADDR_PAGE_PTR  = 4'h2;
  localparam logic [3:0]  ADDR_ERASE_PG  = 4'h3;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam int          BIT_GO         = 15;
  localparam int          BIT_WPERMIT    = 14;
  localparam int          BIT_ERASE      = 6;
  localparam logic [3:0]  OP_PAGE_ERASE  = 4'h2;
  localparam logic [3:0]  OP_ROW_PROGRAM = 4'h1;
  localparam logic [7:0]  KEY_FIRST      = 8'h55;
  localparam logic [7:0]  KEY_SECOND     = 8'hAA;
  localparam logic [15:0] CONTROL_RESET  = 16'h0000;
  localparam logic [15:0] CONTROL_WMASK  = 16'h404F;
  localparam int          ROW_WORDS      = 64;
  localparam int          PAGE_ROWS      = 8;
  localparam int          PAGE_WORDS     = 512;
  localparam int          ERASE_TIME_NS  = 20000;
  localparam int          PROG_TIME_NS   = 1600;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          ERASE_CYCLES   = ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int          PROG_CYCLES    = PROG_TIME_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {FPS_IDLE, FPS_ERASE, FPS_PROG} fps_state_t;
  typedef enum logic [1:0] {KEY_NONE, KEY_GOT55, KEY_OPEN} fps_key_t;
endpackage

// >>> bench/fps_seq_chk.sv
`timescale 1ns/100ps
module fps_seq_chk
  import fps_pkg::*;
#(
  parameter int ADDR_W    = 16,
  parameter int ERASE_CYC = 20,
  parameter int PROG_CYC  = 5
) (
  input wire logic              i_mclk, i_rst, i_reg_wr, i_reg_rd, i_tbl_wr_low,
  input wire logic [3:0]        i_reg_addr,
  input wire logic [15:0]       i_reg_wdata, i_tbl_offset, o_reg_rdata,
  input wire logic              o_cpu_stall, o_flash_erase, o_flash_program,
  input wire logic [ADDR_W-1:0] o_flash_addr
);
  logic [15:0] cnt_r;
  wire go = i_reg_wr && i_reg_addr == ADDR_CONTROL && i_reg_wdata[BIT_GO];
  wire k1 = i_reg_wr && i_reg_addr == ADDR_KEY && i_reg_wdata[7:0] == KEY_FIRST;
  wire k2 = i_reg_wr && i_reg_addr == ADDR_KEY && i_reg_wdata[7:0] == KEY_SECOND;
  wire ek = i_reg_wdata[3:0] == OP_PAGE_ERASE && i_reg_wdata[BIT_ERASE];
  wire pk = i_reg_wdata[3:0] == OP_ROW_PROGRAM && !i_reg_wdata[BIT_ERASE];
  wire ers_ok = go && ek && i_reg_wdata[BIT_WPERMIT];
  wire prg_ok = go && pk && i_reg_wdata[BIT_WPERMIT];
  // Length of the current stall, sampled when it ends
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) cnt_r <= '0;
    else cnt_r <= o_cpu_stall ? cnt_r + 16'h1 : 16'h0;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_key_before_go: assert property (
    $rose(o_cpu_stall) |-> $past(go) && $past(k2, 2) && $past(k1, 3)) else $error("bad key");
  a_erase_bits: assert property (
    $rose(o_flash_erase) |-> $past(ers_ok)) else $error("bad erase start");
  a_prog_bits: assert property (
    $rose(o_flash_program) |-> $past(prg_ok)) else $error("bad program start");
  a_permit_clear: assert property (
    go && !i_reg_wdata[BIT_WPERMIT] && !o_cpu_stall |=> !o_cpu_stall) else $error("no permit");
  a_stall_op: assert property (
    o_cpu_stall == (o_flash_erase || o_flash_program)) else $error("stall mismatch");
  a_erase_len: assert property (
    $fell(o_flash_erase) |-> cnt_r == ERASE_CYC) else $error("erase length");
  a_prog_len: assert property (
    $fell(o_flash_program) |-> cnt_r == PROG_CYC) else $error("program length");
  a_page_base: assert property (
    o_flash_erase |-> o_flash_addr[9:0] == 10'h000) else $error("page not aligned");
  c_erase: cover property ($rose(o_flash_erase));
  c_prog: cover property ($rose(o_flash_program));
  c_refuse: cover property (go && !i_reg_wdata[BIT_WPERMIT]);
endmodule
bind fps_seq fps_seq_chk #(.ADDR_W(ADDR_W), .ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) i_chk (.*);

// >>> bench/fps_core_model.sv
`timescale 1ns/100ps
module fps_core_model
  import fps_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_stall,
  output logic      [3:0]  o_addr,
  output logic      [15:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd,
  output logic             o_tbl
);
  initial {o_addr, o_wdata, o_wr, o_rd, o_tbl} = '0;
  // Called just after a rising edge; one idle cycle follows each access
  task wr(input logic [3:0] a, input logic [15:0] d);
    {o_addr, o_wdata, o_wr} <= {a, d, 1'b1};
    @(posedge i_mclk) o_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task rd(input logic [3:0] a);
    {o_addr, o_rd} <= {a, 1'b1};
    @(posedge i_mclk) o_rd <= 1'b0;
    @(posedge i_mclk);
  endtask
  task tbl(input logic [15:0] d);
    {o_wdata, o_tbl} <= {d, 1'b1};
    @(posedge i_mclk) o_tbl <= 1'b0;
    @(posedge i_mclk);
  endtask
  // Key and go back to back, nothing may slip in between
  task start(input logic [15:0] c);
    {o_addr, o_wdata, o_wr} <= {ADDR_KEY, 8'h00, KEY_FIRST, 1'b1};
    @(posedge i_mclk) o_wdata <= {8'h00, KEY_SECOND};
    @(posedge i_mclk) {o_addr, o_wdata} <= {ADDR_CONTROL, c};
    @(posedge i_mclk) o_wr <= 1'b0;
    repeat (2) @(posedge i_mclk);
    repeat (100) if (i_stall) @(posedge i_mclk);
  endtask
endmodule

// >>> bench/test_fps_seq.sv
`timescale 1ns/100ps
module test_fps_seq;
  import fps_pkg::*;
  logic        i_mclk = 0, i_rst = 1, wr, rd, tbl, stall, erase, prog, rd_d = 0, er_d = 0;
  logic [3:0]  addr;
  logic [15:0] wd, rdata, faddr, pg, off;
  logic [15:0] q[$];
  int          n_errors = 0, checked = 0;
  initial forever #5 i_mclk = ~i_mclk;
  fps_seq #(.ERASE_CYC(20), .PROG_CYC(5)) i_fps_seq (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_tbl_wr_low(tbl), .i_tbl_offset(wd), .o_cpu_stall(stall), .o_flash_erase(erase),
    .o_flash_program(prog), .o_flash_addr(faddr));
  fps_core_model i_fps_core_model (.i_mclk(i_mclk), .i_stall(stall), .o_addr(addr),
    .o_wdata(wd), .o_wr(wr), .o_rd(rd), .o_tbl(tbl));
  task chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      $display("Error at %0t seen %h expected %h", $time, s, e);
      n_errors++;
    end
  endtask
  task rdx(input logic [3:0] a, input logic [15:0] e);
    q.push_back(e);
    i_fps_core_model.rd(a);
  endtask
  task end_sim;
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    rd_d <= rd;
    er_d <= erase;
    if (rd_d === 1'b1) chk(rdata, q.pop_front());
    if (erase === 1'b1 && er_d !== 1'b1) chk(faddr, q.pop_front());
  end
  initial begin
    #100000 n_errors++;
    end_sim;
  end
  initial begin
    void'($urandom(32'hC1C1));
    pg = $urandom;
    off = $urandom;
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    rdx(ADDR_CONTROL, CONTROL_RESET);
    i_fps_core_model.wr(ADDR_PAGE_PTR, pg);
    i_fps_core_model.tbl(off);
    q.push_back({off[15:10], 10'h000});
    i_fps_core_model.start(16'hC042);
    rdx(ADDR_CONTROL, 16'h4042);
    rdx(ADDR_STATUS, 16'h0002);
    for (int i = 0; i < ROW_WORDS; i++) i_fps_core_model.tbl($urandom);
    i_fps_core_model.start(16'hC001);
    rdx(ADDR_CONTROL, 16'h4001);
    i_fps_core_model.wr(ADDR_STATUS, 16'h0006);
    // Stray write inside the key pair must refuse the start
    i_fps_core_model.wr(ADDR_KEY, 16'h0055);
    i_fps_core_model.wr(ADDR_PAGE_PTR, pg);
    i_fps_core_model.wr(ADDR_KEY, 16'h00AA);
    i_fps_core_model.wr(ADDR_CONTROL, 16'hC042);
    rdx(ADDR_STATUS, 16'h0004);
    i_fps_core_model.wr(ADDR_STATUS, 16'h0006);
    i_fps_core_model.start(16'h8042);
    rdx(ADDR_STATUS, 16'h0004);
    rdx(ADDR_CONTROL, 16'h0042);
    end_sim;
  end
endmodule
